/* rtl/cct_pkg.sv */
// cct_pkg: register map, field positions, reset values and timing for the
// processor clock throttle block.
// assumes a 40 MHz system clock and a 32 kHz suspend clock sampled as a level.
package cct_pkg;

	// i/o offsets from the power-management base
	localparam logic [7:0] OFS_ACPI_CTRL = 8'h04;
	localparam logic [7:0] OFS_GEN_EN = 8'h0e;
	localparam logic [7:0] OFS_PROC_CTRL = 8'h10;
	localparam logic [7:0] OFS_CLK_STATUS = 8'h12;
	localparam logic [7:0] OFS_LEVEL_TWO_READ_REGISTER = 8'h14;
	localparam logic [7:0] OFS_LEVEL_THREE_READ_REGISTER = 8'h15;
	localparam logic [7:0] OFS_GLB_EN = 8'h20;

	// processor_control fields
	localparam int PC_DUTY_LSB = 1;
	localparam int PC_DUTY_W = 3;
	localparam int PC_THROTTLE_EN = 4;
	localparam int PC_CLOCK_CTRL_EN = 5;
	localparam int PC_BURST_EN = 6;
	localparam int PC_CACHE_SLEEP_EN = 7;

	// general_event_enable fields
	localparam int GE_THERMAL = 0;
	localparam int GE_USB = 8;
	localparam int GE_GEN_INPUT = 9;
	localparam int GE_RING = 10;
	localparam int GE_LID = 11;

	// acpi control and global enable fields
	localparam int AC_ACPI_ROUTE = 0;
	localparam int GB_THERMAL_BREAK = 2;

	// status vector order towards the event router
	localparam int EV_THERMAL = 0;
	localparam int EV_USB = 1;
	localparam int EV_GEN_INPUT = 2;
	localparam int EV_RING = 3;
	localparam int EV_LID = 4;
	localparam int EV_COUNT = 5;

	// writable bit masks, reserved bits read zero
	localparam logic [15:0] MASK_GEN_EN = 16'h0f01;
	localparam logic [7:0] MASK_PROC_CTRL = 8'hfe;
	localparam logic [15:0] MASK_GLB_EN = 16'h0004;
	localparam logic [15:0] MASK_ACPI_CTRL = 16'h0001;

	localparam logic [15:0] RST_GEN_EN = 16'h0000;
	localparam logic [7:0] RST_PROC_CTRL = 8'h00;
	localparam logic [15:0] RST_GLB_EN = 16'h0000;
	localparam logic [15:0] RST_ACPI_CTRL = 16'h0000;

	// timing in suspend-clock ticks
	localparam int SUSPEND_CLK_HZ = 32768;
	localparam int THERMAL_OVERRIDE_MS = 2000;
	localparam int THERMAL_TICKS = THERMAL_OVERRIDE_MS * SUSPEND_CLK_HZ / 1000;
	localparam int BURST_TICKS = 4;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_STOP,
		ST_STOP_ARMED,
		ST_THROTTLE,
		ST_BURST
	} cct_state_type;

endpackage

/* rtl/cct_throttle_gen.sv */
// cct_throttle_gen: stop-clock duty generator over one throttle period.
// assumes tick_i is a one-cycle pulse per suspend-clock period.
`timescale 1ns/1ps
`default_nettype none
module cct_throttle_gen #(
	parameter int DUTY_W = 3
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // async reset, active high
	input wire logic tick_i, // suspend clock edge pulse
	input wire logic run_i, // throttling active
	input wire logic [DUTY_W-1:0] duty_i, // duty code
	output logic assert_o // stop-clock request
);

	generate
		if (DUTY_W < 1 || DUTY_W > 8) begin : g_chk
			$error("cct_throttle_gen: DUTY_W out of range");
		end
	endgenerate

	localparam logic [DUTY_W:0] PERIOD = (DUTY_W+1)'(1 << DUTY_W);

	logic [DUTY_W-1:0] phase_reg;
	logic [DUTY_W:0] on_ticks;

	assign on_ticks = PERIOD - {1'b0, duty_i};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= '0;
		end else if (!run_i) begin
			phase_reg <= '0;
		end else if (tick_i) begin
			phase_reg <= phase_reg + 1'b1;
		end
	end

	// code zero is reserved: never asserts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			assert_o <= 1'b0;
		end else begin
			assert_o <= run_i && (duty_i != '0) && ({1'b0, phase_reg} < on_ticks);
		end
	end

endmodule // cct_throttle_gen
`default_nettype wire

/* rtl/cct_event_route.sv */
// cct_event_route: routes enabled status bits to smi, acpi irq, resume and break.
// assumes status inputs are levels held by the status register outside.
`timescale 1ns/1ps
`default_nettype none
module cct_event_route (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // async reset, active high
	input wire logic [cct_pkg::EV_COUNT-1:0] status_i, // status levels
	input wire logic [15:0] gen_en_i, // general_event_enable
	input wire logic acpi_route_i, // route to acpi irq
	output logic smi_n_o, // smi level, active low
	output logic acpi_irq_o, // acpi irq level
	output logic resume_o, // resume pulse
	output logic wake_o // hardware wake pulse
);

	logic [cct_pkg::EV_COUNT-1:0] en;
	logic [cct_pkg::EV_COUNT-1:0] prev_reg;
	logic [cct_pkg::EV_COUNT-1:0] active;
	logic [cct_pkg::EV_COUNT-1:0] rise;
	logic smi_src;
	logic acpi_src;
	logic resume_src;

	assign en[cct_pkg::EV_THERMAL] = gen_en_i[cct_pkg::GE_THERMAL];
	assign en[cct_pkg::EV_USB] = gen_en_i[cct_pkg::GE_USB];
	assign en[cct_pkg::EV_GEN_INPUT] = gen_en_i[cct_pkg::GE_GEN_INPUT];
	assign en[cct_pkg::EV_RING] = gen_en_i[cct_pkg::GE_RING];
	assign en[cct_pkg::EV_LID] = gen_en_i[cct_pkg::GE_LID];
	assign active = status_i & en;
	assign rise = active & ~prev_reg;

	// lid, general input, thermal may reach smi
	assign smi_src = !acpi_route_i && (active[cct_pkg::EV_LID] || active[cct_pkg::EV_GEN_INPUT]
		|| active[cct_pkg::EV_THERMAL]);
	// ring and usb need route enable for acpi irq
	assign acpi_src = acpi_route_i && (active != '0);
	// ring, usb, lid, general input resume; thermal does not
	assign resume_src = (rise & ~(cct_pkg::EV_COUNT'(1) << cct_pkg::EV_THERMAL)) != '0;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_reg <= '0;
			smi_n_o <= 1'b1;
			acpi_irq_o <= 1'b0;
			resume_o <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			prev_reg <= active;
			smi_n_o <= !smi_src;
			acpi_irq_o <= acpi_src;
			resume_o <= resume_src;
			wake_o <= rise != '0;
		end
	end

endmodule // cct_event_route
`default_nettype wire

/* rtl/cct_clock_throttle.sv */
// cct_clock_throttle: processor stop-clock / cache-sleep control with manual
// throttling, level-two/three entry, break and burst events and thermal override.
// assumes a synchronous i/o port with one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
module cct_clock_throttle #(
	parameter int THERMAL_TICKS = cct_pkg::THERMAL_TICKS
) (
	input wire logic clk_i, // 40 MHz system clock
	input wire logic rst_i, // async reset, active high
	input wire logic suspend_clk_i, // 32 kHz suspend clock, sampled
	input wire logic [7:0] io_addr_i, // i/o offset
	input wire logic io_rd_i, // read strobe
	input wire logic io_wr_i, // write strobe
	input wire logic [15:0] io_wdata_i, // write data
	output logic [15:0] io_rdata_o, // read data, next cycle
	input wire logic thermal_alarm_n_i, // thermal alarm, active low
	input wire logic lid_event_status_i, // lid status level
	input wire logic ring_event_status_i, // ring status level
	input wire logic usb_wake_status_bit_i, // usb status level
	input wire logic general_input_event_status_i, // gpi status level
	input wire logic thermal_event_status_i, // thermal status level
	output logic cpu_stop_clock_n_o, // stop-clock, active low
	output logic cache_sleep_out_o, // cache sleep, active high
	output logic system_management_irq_n_o, // smi, active low
	output logic acpi_irq_o, // acpi interrupt level
	output logic resume_event_o // resume pulse
);

	generate
		if (THERMAL_TICKS < 1 || THERMAL_TICKS > 131070) begin : g_chk
			$error("cct_clock_throttle: THERMAL_TICKS out of range");
		end
	endgenerate

	localparam logic [16:0] THERMAL_LIMIT = 17'(THERMAL_TICKS);
	localparam logic [2:0] BURST_LAST = 3'(cct_pkg::BURST_TICKS - 1);

	logic [15:0] gen_en_reg;
	logic [7:0] proc_ctrl_reg;
	logic [15:0] glb_en_reg;
	logic [15:0] acpi_ctrl_reg;
	cct_pkg::cct_state_type state_reg;
	cct_pkg::cct_state_type state_next;
	logic slow_prev_reg;
	logic [16:0] thermal_cnt_reg;
	logic override_reg;
	logic thermal_break_reg;
	logic [2:0] burst_cnt_reg;
	logic tick;
	logic clock_ctrl_en;
	logic throttle_en;
	logic burst_en;
	logic level_two_read_register_rd;
	logic lvl_rd;
	logic wake;
	logic brk_evt;
	logic throttling;
	logic pwm_on;
	logic stop_assert;
	logic in_stop;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = addr == ofs;
	endfunction

	assign tick = suspend_clk_i && !slow_prev_reg;
	assign clock_ctrl_en = proc_ctrl_reg[cct_pkg::PC_CLOCK_CTRL_EN];
	assign throttle_en = proc_ctrl_reg[cct_pkg::PC_THROTTLE_EN];
	assign burst_en = proc_ctrl_reg[cct_pkg::PC_BURST_EN];
	assign level_two_read_register_rd = io_rd_i && hit(io_addr_i, cct_pkg::OFS_LEVEL_TWO_READ_REGISTER);
	assign lvl_rd = level_two_read_register_rd || (io_rd_i && hit(io_addr_i, cct_pkg::OFS_LEVEL_THREE_READ_REGISTER));
	assign in_stop = state_reg == cct_pkg::ST_STOP || state_reg == cct_pkg::ST_STOP_ARMED;
	// no gating by the alarm level here
	assign brk_evt = wake || thermal_break_reg;

	// reset high so a slow clock already high at release gives no false tick
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slow_prev_reg <= 1'b1;
		end else begin
			slow_prev_reg <= suspend_clk_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gen_en_reg <= cct_pkg::RST_GEN_EN;
			proc_ctrl_reg <= cct_pkg::RST_PROC_CTRL;
			glb_en_reg <= cct_pkg::RST_GLB_EN;
			acpi_ctrl_reg <= cct_pkg::RST_ACPI_CTRL;
		end else if (io_wr_i) begin
			if (hit(io_addr_i, cct_pkg::OFS_GEN_EN)) begin
				gen_en_reg <= io_wdata_i & cct_pkg::MASK_GEN_EN;
			end
			if (hit(io_addr_i, cct_pkg::OFS_PROC_CTRL)) begin
				proc_ctrl_reg <= io_wdata_i[7:0] & cct_pkg::MASK_PROC_CTRL;
			end
			if (hit(io_addr_i, cct_pkg::OFS_GLB_EN)) begin
				glb_en_reg <= io_wdata_i & cct_pkg::MASK_GLB_EN;
			end
			if (hit(io_addr_i, cct_pkg::OFS_ACPI_CTRL)) begin
				acpi_ctrl_reg <= io_wdata_i & cct_pkg::MASK_ACPI_CTRL;
			end
		end
	end

	// level registers read as zero; the read itself is the trigger
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_rdata_o <= 16'h0000;
		end else if (io_rd_i) begin
			unique case (io_addr_i)
				cct_pkg::OFS_GEN_EN: io_rdata_o <= gen_en_reg;
				cct_pkg::OFS_PROC_CTRL: io_rdata_o <= {8'h00, proc_ctrl_reg};
				cct_pkg::OFS_GLB_EN: io_rdata_o <= glb_en_reg;
				cct_pkg::OFS_ACPI_CTRL: io_rdata_o <= acpi_ctrl_reg;
				cct_pkg::OFS_CLK_STATUS: io_rdata_o <= {10'h000, !cpu_stop_clock_n_o,
					override_reg, 1'b0, state_reg};
				default: io_rdata_o <= 16'h0000;
			endcase
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cct_pkg::ST_RUN: begin
				if (clock_ctrl_en && lvl_rd) begin
					// level-two read with throttle set arms throttling
					state_next = (level_two_read_register_rd && throttle_en) ? cct_pkg::ST_STOP_ARMED : cct_pkg::ST_STOP;
				end else if (clock_ctrl_en && throttle_en) begin
					state_next = cct_pkg::ST_THROTTLE;
				end
			end
			cct_pkg::ST_STOP: begin
				if (!clock_ctrl_en) begin
					state_next = cct_pkg::ST_RUN;
				end else if (brk_evt) begin
					state_next = burst_en ? cct_pkg::ST_BURST : cct_pkg::ST_RUN;
				end
			end
			cct_pkg::ST_STOP_ARMED: begin
				if (!clock_ctrl_en) begin
					state_next = cct_pkg::ST_RUN;
				end else if (brk_evt) begin
					state_next = cct_pkg::ST_THROTTLE;
				end
			end
			cct_pkg::ST_THROTTLE: begin
				// either enable clearing ends it; breaks ignored
				if (!clock_ctrl_en || !throttle_en) begin
					state_next = cct_pkg::ST_RUN;
				end else if (level_two_read_register_rd) begin
					state_next = cct_pkg::ST_STOP_ARMED;
				end
			end
			cct_pkg::ST_BURST: begin
				if (!clock_ctrl_en) begin
					state_next = cct_pkg::ST_RUN;
				end else if (tick && burst_cnt_reg == BURST_LAST) begin
					state_next = cct_pkg::ST_STOP;
				end
			end
			default: state_next = cct_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= cct_pkg::ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			burst_cnt_reg <= 3'h0;
		end else if (state_reg != cct_pkg::ST_BURST) begin
			burst_cnt_reg <= 3'h0;
		end else if (tick) begin
			burst_cnt_reg <= burst_cnt_reg + 3'h1;
		end
	end

	// count alarm time in slow ticks in every state but ST_RUN
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			thermal_cnt_reg <= 17'h0_0000;
		end else if (thermal_alarm_n_i || state_reg == cct_pkg::ST_RUN) begin
			thermal_cnt_reg <= 17'h0_0000;
		end else if (tick && thermal_cnt_reg <= THERMAL_LIMIT) begin
			thermal_cnt_reg <= thermal_cnt_reg + 17'h0_0001;
		end
	end

	// override holds until alarm release or clock control enable clears, state left as it was
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			override_reg <= 1'b0;
		end else if (thermal_alarm_n_i || !clock_ctrl_en) begin
			override_reg <= 1'b0;
		end else if (in_stop && thermal_cnt_reg > THERMAL_LIMIT) begin
			override_reg <= 1'b1;
		end
	end

	// one break pulse as override ends on alarm release
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			thermal_break_reg <= 1'b0;
		end else begin
			thermal_break_reg <= override_reg && thermal_alarm_n_i
				&& glb_en_reg[cct_pkg::GB_THERMAL_BREAK];
		end
	end

	assign throttling = state_reg == cct_pkg::ST_THROTTLE || override_reg;

	cct_throttle_gen #(
		.DUTY_W(cct_pkg::PC_DUTY_W)
	) u_throttle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.run_i(throttling),
		.duty_i(proc_ctrl_reg[cct_pkg::PC_DUTY_LSB +: cct_pkg::PC_DUTY_W]),
		.assert_o(pwm_on)
	);

	cct_event_route u_route (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.status_i({lid_event_status_i, ring_event_status_i, general_input_event_status_i,
			usb_wake_status_bit_i, thermal_event_status_i}),
		.gen_en_i(gen_en_reg),
		.acpi_route_i(acpi_ctrl_reg[cct_pkg::AC_ACPI_ROUTE]),
		.smi_n_o(system_management_irq_n_o),
		.acpi_irq_o(acpi_irq_o),
		.resume_o(resume_event_o),
		.wake_o(wake)
	);

	// throttled toggling, plain stop holds asserted
	assign stop_assert = throttling ? pwm_on : in_stop;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_stop_clock_n_o <= 1'b1;
			cache_sleep_out_o <= 1'b0;
		end else begin
			cpu_stop_clock_n_o <= !stop_assert;
			// cache sleep follows only when enabled
			cache_sleep_out_o <= stop_assert && proc_ctrl_reg[cct_pkg::PC_CACHE_SLEEP_EN];
		end
	end

endmodule // cct_clock_throttle
`default_nettype wire

/* testbench/cct_clock_throttle_sva.sv */
// cct_clock_throttle_sva: port-level checks for the clock throttle block.
// assumes one-cycle i/o strobes and the registered outputs of the design.
`timescale 1ns/1ps
`default_nettype none
module cct_clock_throttle_sva #(
	parameter int THERMAL_TICKS = 4
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic suspend_clk_i, // slow clock
	input wire logic [7:0] io_addr_i, // offset
	input wire logic io_rd_i, // read
	input wire logic io_wr_i, // write
	input wire logic [15:0] io_wdata_i, // wdata
	input wire logic [15:0] io_rdata_o, // rdata
	input wire logic thermal_alarm_n_i, // alarm
	input wire logic lid_event_status_i, // lid
	input wire logic ring_event_status_i, // ring
	input wire logic usb_wake_status_bit_i, // usb
	input wire logic general_input_event_status_i, // gpi
	input wire logic thermal_event_status_i, // thermal
	input wire logic cpu_stop_clock_n_o, // stop
	input wire logic cache_sleep_out_o, // sleep
	input wire logic system_management_irq_n_o, // smi
	input wire logic acpi_irq_o, // acpi
	input wire logic resume_event_o // resume
);
	logic [7:0] pc_reg;
	logic [15:0] ge_reg;
	logic ac_reg;
	logic sleep_en;
	logic smi_src;
	logic acpi_src;
	logic mapped;
	// software view kept here, so readback needs no peek inside
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_reg <= 8'h00;
			ge_reg <= 16'h0000;
			ac_reg <= 1'b0;
		end else if (io_wr_i) begin
			if (io_addr_i == cct_pkg::OFS_PROC_CTRL) pc_reg <= io_wdata_i[7:0] & cct_pkg::MASK_PROC_CTRL;
			if (io_addr_i == cct_pkg::OFS_GEN_EN) ge_reg <= io_wdata_i & cct_pkg::MASK_GEN_EN;
			if (io_addr_i == cct_pkg::OFS_ACPI_CTRL) ac_reg <= io_wdata_i[0];
		end
	end
	assign sleep_en = pc_reg[7];
	assign smi_src = !ac_reg && ((lid_event_status_i && ge_reg[11]) || (general_input_event_status_i && ge_reg[9])
		|| (thermal_event_status_i && ge_reg[0]));
	assign acpi_src = ac_reg && ((lid_event_status_i && ge_reg[11]) || (ring_event_status_i && ge_reg[10])
		|| (usb_wake_status_bit_i && ge_reg[8]) || (general_input_event_status_i && ge_reg[9])
		|| (thermal_event_status_i && ge_reg[0]));
	assign mapped = io_addr_i inside {8'h04, 8'h0e, 8'h10, 8'h12, 8'h20};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_smi_cause: assert property (!system_management_irq_n_o |-> $past(smi_src) || $past(smi_src, 2))
		else $error("smi low without enabled source");
	chk_smi_level: assert property (smi_src [*3] |-> !system_management_irq_n_o)
		else $error("enabled smi source not signalled");
	chk_acpi_cause: assert property (acpi_irq_o |-> $past(acpi_src) || $past(acpi_src, 2))
		else $error("acpi irq without enabled source");
	chk_acpi_level: assert property (acpi_src [*3] |-> acpi_irq_o)
		else $error("enabled acpi source not signalled");
	chk_resume_one_cycle: assert property (resume_event_o |=> !resume_event_o)
		else $error("resume longer than one cycle");
	chk_sleep_needs_stop: assert property (cache_sleep_out_o |-> !cpu_stop_clock_n_o)
		else $error("cache sleep while clock runs");
	chk_sleep_enable: assert property (cache_sleep_out_o |-> sleep_en || $past(sleep_en) || $past(sleep_en, 2))
		else $error("cache sleep while disabled");
	chk_cc_clear_run: assert property (io_wr_i && io_addr_i == cct_pkg::OFS_PROC_CTRL && !io_wdata_i[5]
		|-> ##3 cpu_stop_clock_n_o)
		else $error("stop clock held after enable cleared");
	chk_cc_off_quiet: assert property (!pc_reg[5] [*3] |-> cpu_stop_clock_n_o && !cache_sleep_out_o)
		else $error("stop or sleep asserted with clock control off");
	chk_unmapped_zero: assert property (io_rd_i && !mapped |=> io_rdata_o == 16'h0000)
		else $error("unmapped or level read not zero");
	chk_pc_readback: assert property (io_rd_i && !io_wr_i && io_addr_i == cct_pkg::OFS_PROC_CTRL
		|=> io_rdata_o == {8'h00, pc_reg})
		else $error("processor control readback wrong");
	chk_ge_readback: assert property (io_rd_i && !io_wr_i && io_addr_i == cct_pkg::OFS_GEN_EN
		|=> io_rdata_o == ge_reg)
		else $error("event enable readback wrong");
endmodule // cct_clock_throttle_sva
bind cct_clock_throttle cct_clock_throttle_sva #(.THERMAL_TICKS(THERMAL_TICKS)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.suspend_clk_i(suspend_clk_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
	.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .thermal_alarm_n_i(thermal_alarm_n_i),
	.lid_event_status_i(lid_event_status_i), .ring_event_status_i(ring_event_status_i),
	.usb_wake_status_bit_i(usb_wake_status_bit_i), .general_input_event_status_i(general_input_event_status_i),
	.thermal_event_status_i(thermal_event_status_i), .cpu_stop_clock_n_o(cpu_stop_clock_n_o),
	.cache_sleep_out_o(cache_sleep_out_o), .system_management_irq_n_o(system_management_irq_n_o),
	.acpi_irq_o(acpi_irq_o), .resume_event_o(resume_event_o));
`default_nettype wire

/* testbench/cct_cpu_model.sv */
// cct_cpu_model: processor side of the stop-clock and cache-sleep pins.
// assumes the slow clock is the same one the block sees; counts stopped ticks.
`timescale 1ns/1ps
`default_nettype none
module cct_cpu_model (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // async reset
	input wire logic suspend_clk_i, // slow clock level
	input wire logic clr_i, // restart counts
	input wire logic cpu_stop_clock_n_i, // stop request, low
	input wire logic cache_sleep_i, // cache sleep, high
	output logic [7:0] low_ticks_o, // ticks seen stopped
	output logic [7:0] sleep_ticks_o // ticks seen asleep
);
	logic sus_q;
	// sampled one edge after the slow rise, far from the output change
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sus_q <= 1'b1;
			low_ticks_o <= 8'h00;
			sleep_ticks_o <= 8'h00;
		end else begin
			sus_q <= suspend_clk_i;
			if (clr_i) begin
				low_ticks_o <= 8'h00;
				sleep_ticks_o <= 8'h00;
			end else if (suspend_clk_i && !sus_q) begin
				low_ticks_o <= low_ticks_o + {7'h0, !cpu_stop_clock_n_i};
				sleep_ticks_o <= sleep_ticks_o + {7'h0, cache_sleep_i};
			end
		end
	end
endmodule // cct_cpu_model
`default_nettype wire

/* testbench/tb.sv */
// tb: self-checking bench for the processor clock throttle block.
// assumes the cpu model on the stop pins and a fast stand-in slow clock of 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [15:0] REG_ROWS [6][3] = '{'{16'h0004, 16'hffff, 16'h0001}, '{16'h000e, 16'hffff, 16'h0f01},
		'{16'h0020, 16'hffff, 16'h0004}, '{16'h0030, 16'hffff, 16'h0000}, '{16'h0014, 16'hffff, 16'h0000},
		'{16'h0010, 16'h00ff, 16'h00fe}};
	// route, status index, enable bit, then smi_n, acpi, resume
	localparam logic [10:0] EV_ROWS [11] = '{{1'b0, 3'd4, 4'd11, 3'b001}, {1'b1, 3'd4, 4'd11, 3'b111},
		{1'b0, 3'd3, 4'd10, 3'b101}, {1'b1, 3'd3, 4'd10, 3'b111}, {1'b0, 3'd1, 4'd8, 3'b101},
		{1'b1, 3'd1, 4'd8, 3'b111}, {1'b0, 3'd2, 4'd9, 3'b001}, {1'b1, 3'd2, 4'd9, 3'b111},
		{1'b0, 3'd0, 4'd0, 3'b000}, {1'b1, 3'd0, 4'd0, 3'b110}, {1'b1, 3'd4, 4'd8, 3'b100}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sus_clk = 1'b0;
	logic io_rd = 1'b0;
	logic io_wr = 1'b0;
	logic alarm_n = 1'b1;
	logic clr = 1'b0;
	logic [2:0] div = 3'h0;
	logic [4:0] st = 5'h00;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [7:0] low_ticks, sleep_ticks;
	logic [15:0] rdata, rv;
	logic stop_n, sleep, smi_n, acpi, resume;
	int bad_count = 0;
	int num_checks = 0;
	int res_cnt = 0;
	int cyc = 0;
	int k, c0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		div <= div + 3'h1;
		if (div == 3'h7) sus_clk <= ~sus_clk;
		if (resume === 1'b1) res_cnt++;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	cct_clock_throttle #(.THERMAL_TICKS(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .suspend_clk_i(sus_clk),
		.io_addr_i(addr), .io_rd_i(io_rd), .io_wr_i(io_wr), .io_wdata_i(wdata), .io_rdata_o(rdata),
		.thermal_alarm_n_i(alarm_n), .lid_event_status_i(st[4]), .ring_event_status_i(st[3]),
		.usb_wake_status_bit_i(st[1]), .general_input_event_status_i(st[2]), .thermal_event_status_i(st[0]),
		.cpu_stop_clock_n_o(stop_n), .cache_sleep_out_o(sleep), .system_management_irq_n_o(smi_n),
		.acpi_irq_o(acpi), .resume_event_o(resume));
	cct_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .suspend_clk_i(sus_clk), .clr_i(clr),
		.cpu_stop_clock_n_i(stop_n), .cache_sleep_i(sleep), .low_ticks_o(low_ticks), .sleep_ticks_o(sleep_ticks));
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk_i);
		io_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		io_rd <= 1'b1;
		@(posedge clk_i);
		io_rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge sus_clk);
	endtask
	// counts over whole periods, so the phase of the pattern does not matter
	task automatic meas(input int n, input logic [7:0] e, input logic [7:0] s);
		@(posedge clk_i) clr <= 1'b1;
		@(posedge clk_i) clr <= 1'b0;
		ticks(n);
		repeat (2) @(posedge clk_i);
		#1 chk({low_ticks, sleep_ticks}, {e, s});
	endtask
	task automatic brk;
		@(posedge clk_i) st[4] <= 1'b0;
		repeat (2) @(posedge clk_i);
		st[4] <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 6; k++) begin
			wr(REG_ROWS[k][0][7:0], REG_ROWS[k][1]);
			rd(REG_ROWS[k][0][7:0], rv);
			chk(rv, REG_ROWS[k][2]);
		end
		wr(8'h10, 16'h0000);
		for (k = 0; k < 11; k++) begin
			wr(8'h04, {15'h0, EV_ROWS[k][10]});
			wr(8'h0e, 16'h0001 << EV_ROWS[k][6:3]);
			c0 = res_cnt;
			st[EV_ROWS[k][9:7]] <= 1'b1;
			repeat (4) @(posedge clk_i);
			#1 chk({13'h0, smi_n, acpi, res_cnt == c0 + 1}, {13'h0, EV_ROWS[k][2:0]});
			@(posedge clk_i) st <= 5'h00;
			repeat (3) @(posedge clk_i);
		end
		for (k = 0; k < 8; k++) begin
			wr(8'h10, 16'h00b0 | (16'(k) << 1));
			ticks(2);
			c0 = (k == 0) ? 0 : 16 - 2 * k;
			meas(16, 8'(c0), 8'(c0));
		end
		wr(8'h0e, 16'h0800);
		wr(8'h04, 16'h0000);
		wr(8'h10, 16'h0034);
		ticks(2);
		brk();
		meas(16, 8'h0c, 8'h00);
		wr(8'h10, 16'h0024);
		meas(8, 8'h00, 8'h00);
		wr(8'h10, 16'h0014);
		meas(8, 8'h00, 8'h00);
		wr(8'h10, 16'h0034);
		rd(8'h14, rv);
		ticks(1);
		meas(8, 8'h08, 8'h00);
		rd(8'h12, rv);
		chk(rv, 16'h0022);
		brk();
		meas(16, 8'h0c, 8'h00);
		wr(8'h10, 16'h0020);
		rd(8'h15, rv);
		ticks(1);
		meas(4, 8'h04, 8'h00);
		rd(8'h12, rv);
		chk(rv, 16'h0021);
		brk();
		meas(8, 8'h00, 8'h00);
		wr(8'h10, 16'h0060);
		rd(8'h14, rv);
		ticks(1);
		meas(4, 8'h04, 8'h00);
		brk();
		meas(3, 8'h00, 8'h00);
		ticks(3);
		meas(4, 8'h04, 8'h00);
		wr(8'h10, 16'h0000);
		meas(4, 8'h00, 8'h00);
		wr(8'h10, 16'h0028);
		rd(8'h14, rv);
		@(posedge clk_i) alarm_n <= 1'b0;
		brk();
		meas(4, 8'h00, 8'h00);
		for (k = 0; k < 2; k++) begin
			wr(8'h20, 16'(4 * k));
			rd(8'h14, rv);
			@(posedge clk_i) alarm_n <= 1'b0;
			ticks(8);
			meas(16, 8'h08, 8'h00);
			@(posedge clk_i) alarm_n <= 1'b1;
			ticks(2);
			meas(4, 8'(4 - 4 * k), 8'h00);
		end
		wr(8'h10, 16'h0034);
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 3; k++) begin
			rd(REG_ROWS[k][0][7:0], rv);
			chk(rv, 16'h0000);
		end
		rd(8'h10, rv);
		chk(rv, 16'h0000);
		meas(4, 8'h00, 8'h00);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
